/* shared/crbt_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef CRBT_REGS_SVH
`define CRBT_REGS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CRBT_OFF_CTRL     8'h00
`define CRBT_OFF_CNT_LO   8'h04
`define CRBT_OFF_CNT_HI   8'h08
`define CRBT_OFF_CAP_LO   8'h0C
`define CRBT_OFF_CAP_HI   8'h10

// ------------------------------------------------------------
// third_timer_control bit positions
// ------------------------------------------------------------
`define CRBT_B_OVF        7
`define CRBT_B_EXF        6
`define CRBT_B_RCLK       5
`define CRBT_B_TRANSMIT_CLOCK_SELECT       4
`define CRBT_B_EXEN       3
`define CRBT_B_RUN        2
`define CRBT_B_CNTSEL     1
`define CRBT_B_CAPSEL     0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CRBT_RST_CTRL     8'h00
`define CRBT_RST_BYTE     8'h00

// ------------------------------------------------------------
// timing and limits: oscillator periods per machine cycle and state time, baud divide, interrupt vector, count maximum
// ------------------------------------------------------------
`define CRBT_MC_DIV       4'hC
`define CRBT_ST_DIV       4'h2
`define CRBT_BAUD_DIV     4'hF
`define CRBT_VECTOR       16'h002B
`define CRBT_CNT_MAX      16'hFFFF

`endif

/* shared/crbt_pkg.sv */
// types shared by the capture/reload/baud timer
package crbt_pkg;

  // ------------------------------------------------------------
  // bus slave states, one-hot
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    BS_IDLE  = 4'b0001,
    BS_WRITE = 4'b0010,
    BS_READ  = 4'b0100,
    BS_RDATA = 4'b1000
  } crbt_bus_state_t;

  // ------------------------------------------------------------
  // operating mode decoded from the control register
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    MD_OFF     = 4'b0001,
    MD_RELOAD  = 4'b0010,
    MD_CAPTURE = 4'b0100,
    MD_BAUD    = 4'b1000
  } crbt_mode_t;

endpackage

/* verilog/crbt_timer.sv */
// third timer/counter: capture, auto-reload and baud generator
`include "crbt_regs.svh"

module crbt_timer
  import crbt_pkg::*;
(
  input  wire logic        hclk,          // oscillator clock
  input  wire logic        hresetn,       // async reset, low
  input  wire logic        hsel,          // slave select
  input  wire logic [7:0]  haddr,         // byte address
  input  wire logic [1:0]  htrans,        // transfer type
  input  wire logic        hwrite,        // write access
  input  wire logic [2:0]  hsize,         // transfer size
  input  wire logic        hready,        // bus ready in
  input  wire logic [31:0] hwdata,        // write data
  output logic      [31:0] hrdata,        // read data
  output logic             hreadyout,     // slave ready
  output logic             hresp,         // always okay
  input  wire logic        trigger_pin,   // async trigger pin
  input  wire logic        count_input_pin, // async count pin
  input  wire logic        timer_one_overflow, // pulse
  input  wire logic [1:0]  serial_mode,   // serial port mode
  output logic             rx_clock_pulse, // receive clock
  output logic             tx_clock_pulse, // transmit clock
  output logic             rx_bit_tick,   // receive bit rate
  output logic             tx_bit_tick,   // transmit bit rate
  output logic             timer_irq,     // interrupt request
  output logic      [15:0] irq_vector     // fixed vector
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  crbt_bus_state_t bus_r;
  crbt_mode_t      mode;
  logic [7:0]  ctrl_r;
  logic [15:0] count_r;
  logic [15:0] cap_r;
  logic [7:0]  addr_r;
  logic [31:0] hrdata_r;
  logic [3:0]  mc_cnt_r;
  logic [3:0]  st_cnt_r;
  logic        mc_en;
  logic        st_en;
  logic [2:0]  trig_sync_r;
  logic [2:0]  cnt_sync_r;
  logic        trig_fall;
  logic        cnt_fall;
  logic        baud;
  logic        tick;
  logic        ovf;
  logic        ext_evt;
  logic        accept;
  logic        wr_en;
  logic [7:0]  wbyte;
  logic [7:0]  rd_val;
  logic [1:0]  bit_pulse;
  logic [1:0]  bit_tick_r;

  // ------------------------------------------------------------
  // clock enables from the oscillator
  // ------------------------------------------------------------
  // machine cycle: one pulse every twelve oscillator periods
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mc_cnt_r <= 4'h0;
    end else if (mc_cnt_r == `CRBT_MC_DIV - 4'h1) begin
      mc_cnt_r <= 4'h0;
    end else begin
      mc_cnt_r <= mc_cnt_r + 4'h1;
    end
  end

  // state time: one pulse every two oscillator periods
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_cnt_r <= 4'h0;
    end else if (st_cnt_r == `CRBT_ST_DIV - 4'h1) begin
      st_cnt_r <= 4'h0;
    end else begin
      st_cnt_r <= st_cnt_r + 4'h1;
    end
  end

  assign mc_en = (mc_cnt_r == `CRBT_MC_DIV - 4'h1);
  assign st_en = (st_cnt_r == `CRBT_ST_DIV - 4'h1);

  // ------------------------------------------------------------
  // pin synchronisers and falling edge detect
  // ------------------------------------------------------------
  // stage 0 feeds only stage 1; the edge looks at stages 1 and 2
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_sync_r <= 3'h7;
      cnt_sync_r  <= 3'h7;
    end else begin
      trig_sync_r <= {trig_sync_r[1:0], trigger_pin};
      cnt_sync_r  <= {cnt_sync_r[1:0], count_input_pin};
    end
  end

  assign trig_fall = trig_sync_r[2] & ~trig_sync_r[1];
  assign cnt_fall  = cnt_sync_r[2] & ~cnt_sync_r[1];

  // ------------------------------------------------------------
  // mode decode and counting
  // ------------------------------------------------------------
  assign baud = ctrl_r[`CRBT_B_RCLK] | ctrl_r[`CRBT_B_TRANSMIT_CLOCK_SELECT];

  // baud wins over the capture/reload select
  always_comb begin
    if (!ctrl_r[`CRBT_B_RUN]) begin
      mode = MD_OFF;
    end else if (baud) begin
      mode = MD_BAUD;
    end else if (ctrl_r[`CRBT_B_CAPSEL]) begin
      mode = MD_CAPTURE;
    end else begin
      mode = MD_RELOAD;
    end
  end

  // count source: pin edge, state time in baud, else machine cycle
  always_comb begin
    if (ctrl_r[`CRBT_B_CNTSEL]) begin
      tick = cnt_fall;
    end else if (baud) begin
      tick = st_en;
    end else begin
      tick = mc_en;
    end
    tick = tick & ctrl_r[`CRBT_B_RUN];
  end

  assign ovf = tick & (count_r == `CRBT_CNT_MAX);
  // trigger events only with the external enable set, even when off
  assign ext_evt = trig_fall & ctrl_r[`CRBT_B_EXEN];

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  assign accept = hsel & hready & htrans[1];
  assign wr_en  = (bus_r == BS_WRITE);
  assign wbyte  = hwdata[7:0];

  // reads take one wait state so an earlier write has landed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_r <= BS_IDLE;
    end else begin
      case (bus_r)
        BS_READ: begin
          bus_r <= BS_RDATA;
        end
        BS_IDLE, BS_WRITE, BS_RDATA: begin
          if (accept && hwrite) begin
            bus_r <= BS_WRITE;
          end else if (accept) begin
            bus_r <= BS_READ;
          end else begin
            bus_r <= BS_IDLE;
          end
        end
        default: begin
          bus_r <= BS_IDLE;
        end
      endcase
    end
  end

  // address latched in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= 8'h00;
    end else if (accept && (bus_r != BS_READ)) begin
      addr_r <= haddr;
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    case (addr_r)
      `CRBT_OFF_CTRL:   rd_val = ctrl_r;
      `CRBT_OFF_CNT_LO: rd_val = count_r[7:0];
      `CRBT_OFF_CNT_HI: rd_val = count_r[15:8];
      `CRBT_OFF_CAP_LO: rd_val = cap_r[7:0];
      `CRBT_OFF_CAP_HI: rd_val = cap_r[15:8];
      default:          rd_val = 8'h00;
    endcase
  end

  // read data registered during the wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (bus_r == BS_READ) begin
      hrdata_r <= {24'h00_0000, rd_val};
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = (bus_r != BS_READ);
  assign hresp     = 1'b0;

  // ------------------------------------------------------------
  // control register and flags
  // ------------------------------------------------------------
  // software writes land first, hardware sets win over a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `CRBT_RST_CTRL;
    end else begin
      if (wr_en && addr_r == `CRBT_OFF_CTRL) begin
        ctrl_r <= wbyte;
      end
      if (ovf && !baud) begin
        ctrl_r[`CRBT_B_OVF] <= 1'b1;
      end
      if (ext_evt) begin
        ctrl_r[`CRBT_B_EXF] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // count register
  // ------------------------------------------------------------
  // a software write overrides a tick in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= {`CRBT_RST_BYTE, `CRBT_RST_BYTE};
    end else if (wr_en && addr_r == `CRBT_OFF_CNT_LO) begin
      count_r[7:0] <= wbyte;
    end else if (wr_en && addr_r == `CRBT_OFF_CNT_HI) begin
      count_r[15:8] <= wbyte;
    end else if (ext_evt && mode == MD_RELOAD) begin
      count_r <= cap_r;
    end else if (ovf && (mode == MD_RELOAD || baud)) begin
      count_r <= cap_r;
    end else if (tick) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // capture registers
  // ------------------------------------------------------------
  // a hardware capture wins so the trigger event is not lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_r <= {`CRBT_RST_BYTE, `CRBT_RST_BYTE};
    end else if (ext_evt && mode == MD_CAPTURE) begin
      cap_r <= count_r;
    end else if (wr_en && addr_r == `CRBT_OFF_CAP_LO) begin
      cap_r[7:0] <= wbyte;
    end else if (wr_en && addr_r == `CRBT_OFF_CAP_HI) begin
      cap_r[15:8] <= wbyte;
    end
  end

  // ------------------------------------------------------------
  // serial port clocks
  // ------------------------------------------------------------
  // overflow pulses still leave in baud mode though no flag is set
  assign rx_clock_pulse = ctrl_r[`CRBT_B_RCLK] ? ovf
                                               : timer_one_overflow;
  assign tx_clock_pulse = ctrl_r[`CRBT_B_TRANSMIT_CLOCK_SELECT] ? ovf
                                               : timer_one_overflow;
  assign bit_pulse = {tx_clock_pulse, rx_clock_pulse};

  // divide each clock by sixteen in serial modes 1 and 3 only
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_bit
      logic [3:0] div_r;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          div_r         <= 4'h0;
          bit_tick_r[g] <= 1'b0;
        end else if (!serial_mode[0]) begin
          div_r         <= 4'h0;
          bit_tick_r[g] <= 1'b0;
        end else begin
          bit_tick_r[g] <= bit_pulse[g] &&
                           (div_r == `CRBT_BAUD_DIV);
          if (bit_pulse[g]) begin
            div_r <= div_r + 4'h1;
          end
        end
      end
    end
  endgenerate

  assign rx_bit_tick = bit_tick_r[0];
  assign tx_bit_tick = bit_tick_r[1];

  // ------------------------------------------------------------
  // interrupt request
  // ------------------------------------------------------------
  // flags stay set until software clears them; no vector clear
  assign timer_irq  = ctrl_r[`CRBT_B_OVF] |
                      ctrl_r[`CRBT_B_EXF];
  assign irq_vector = `CRBT_VECTOR;

endmodule

/* dv/crbt_timer_asserts.sv */
// concurrent checks on the third timer's ports
module crbt_timer_asserts (
  input wire logic        hclk,               // clock
  input wire logic        hresetn,            // reset, low
  input wire logic        hsel,               // select
  input wire logic [1:0]  htrans,             // transfer type
  input wire logic        hwrite,             // write
  input wire logic        hready,             // bus ready
  input wire logic [7:0]  haddr,              // address
  input wire logic [31:0] hwdata,             // write data
  input wire logic        hreadyout,          // slave ready
  input wire logic        trigger_pin,        // trigger pin
  input wire logic        timer_one_overflow, // timer one
  input wire logic [1:0]  serial_mode,        // serial mode
  input wire logic        rx_clock_pulse,     // rx clock
  input wire logic        tx_clock_pulse,     // tx clock
  input wire logic        rx_bit_tick,        // rx bit rate
  input wire logic        tx_bit_tick,        // tx bit rate
  input wire logic        timer_irq,          // interrupt
  input wire logic [15:0] irq_vector          // vector
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       wph;  // write data phase
  logic [7:0] wa;   // write address
  logic [7:0] ctl;  // control shadow
  // ----------
  // shadow of the control bits that only software changes
  // ----------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph <= 1'b0;
      wa <= 8'h00;
      ctl <= 8'h00;
    end else begin
      if (hreadyout) begin
        wph <= hsel && hready && htrans[1] && hwrite;
        wa <= haddr;
      end
      if (wph && hreadyout && wa == 8'h00) ctl <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_vector_fixed: assert property (irq_vector == 16'h002B)
    else $error("vector is not 002B");
  chk_rx_source: assert property (
    !ctl[5] |-> rx_clock_pulse == timer_one_overflow)
    else $error("receive clock not from timer one");
  chk_tx_source: assert property (
    !ctl[4] |-> tx_clock_pulse == timer_one_overflow)
    else $error("transmit clock not from timer one");
  chk_baud_no_irq: assert property (
    (ctl[5] || ctl[4]) && !ctl[3] && !wph |=> !$rose(timer_irq))
    else $error("baud overflow raised the interrupt");
  chk_idle_quiet: assert property (
    !ctl[2] && !ctl[3] && !wph && !timer_irq |=> !timer_irq)
    else $error("stopped timer raised the interrupt");
  chk_irq_sticky: assert property (timer_irq && !wph |=> timer_irq)
    else $error("flag cleared without software");
  chk_trig_event: assert property (
    $fell(trigger_pin) && ctl[3] && !wph |-> ##[1:4] timer_irq)
    else $error("trigger fall did not set the flag");
  chk_read_wait: assert property (
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state");
  chk_tick_gated: assert property (
    !serial_mode[0] |=> !rx_bit_tick && !tx_bit_tick)
    else $error("bit tick outside modes 1 and 3");
  cover property (rx_bit_tick);
  cover property ($rose(timer_irq));
  cover property (ctl[4] && tx_clock_pulse);
endmodule

bind crbt_timer crbt_timer_asserts u_chk (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .haddr, .hwdata, .hreadyout, .trigger_pin,
  .timer_one_overflow, .serial_mode, .rx_clock_pulse, .tx_clock_pulse,
  .rx_bit_tick, .tx_bit_tick, .timer_irq, .irq_vector);

/* dv/crbt_pin_model.sv */
// pin-side partner: trigger line, count line and timer one
module crbt_pin_model (
  input  wire logic hclk,               // clock
  input  wire logic hresetn,            // reset, low
  input  wire logic trig_go,            // one trigger fall
  input  wire logic cnt_go,             // five count falls
  output logic      trigger_pin,        // pulled-up trigger line
  output logic      count_input_pin,    // pulled-up count line
  output logic      timer_one_overflow  // one-cycle pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] tc;  // trigger low time
  logic [5:0] cc;  // count burst
  logic [5:0] oc;  // timer one divider
  // pins rest high as the pull-ups leave them between requests
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tc <= 3'h0;
      cc <= 6'h00;
      oc <= 6'h00;
    end else begin
      oc <= oc + 6'h01;
      if (trig_go) tc <= 3'h6;
      else if (tc != 3'h0) tc <= tc - 3'h1;
      if (cnt_go) cc <= 6'h27;
      else if (cc != 6'h00) cc <= cc - 6'h01;
    end
  end
  // low for six clocks, long enough for a two-stage synchroniser
  assign trigger_pin = (tc == 3'h0);
  assign count_input_pin = (cc == 6'h00) | cc[2];
  assign timer_one_overflow = (oc == 6'h00);
endmodule

/* dv/test_capture_reload_baud_timer.sv */
// self-checking bench for the third timer
`include "crbt_regs.svh"
module test_capture_reload_baud_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hsel = 0, hwrite = 0, hresetn = 0, trig_go = 0;
  logic        cnt_go = 0, hready, hreadyout, hresp, timer_irq;
  logic        trigger_pin, count_input_pin, timer_one_overflow;
  logic        rx_clock_pulse, tx_clock_pulse, rx_bit_tick, tx_bit_tick;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00, serial_mode = 2'b00;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic [15:0] irq_vector;
  logic [31:0] expq[$];
  logic [7:0]  al[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  int          miscompares = 0, checked = 0, ticks = 0;
  logic        rd_ph = 0;
  assign hready = hreadyout;
  crbt_timer dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready, .hwdata, .hrdata, .hreadyout, .hresp, .trigger_pin,
    .count_input_pin, .timer_one_overflow, .serial_mode, .rx_clock_pulse,
    .tx_clock_pulse, .rx_bit_tick, .tx_bit_tick, .timer_irq, .irq_vector);
  crbt_pin_model u_pins (.hclk, .hresetn, .trig_go, .cnt_go, .trigger_pin,
    .count_input_pin, .timer_one_overflow);
  // ----------
  // helpers
  // ----------
  initial begin
    hclk = 0;
    forever #4 hclk = ~hclk;
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  // address phase held until accepted, then data phase until ready
  task automatic xfer(input logic w, input logic [7:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= a;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, e);
    expq.push_back({24'h0, e});
    xfer(1'b0, a, 8'h00);
  endtask
  task automatic pulse(input logic t);
    @(posedge hclk);
    if (t) trig_go <= 1'b1;
    else cnt_go <= 1'b1;
    @(posedge hclk);
    trig_go <= 1'b0;
    cnt_go <= 1'b0;
    repeat (60) @(posedge hclk);
  endtask
  // values seen here are those from before the edge's updates
  always @(posedge hclk) begin
    if (rx_bit_tick === 1'b1) ticks++;
    if (tx_bit_tick === 1'b1) ticks++;
    if (rd_ph && hreadyout === 1'b1) begin
      check("hrdata", hrdata, expq.pop_front());
      check("hresp", hresp, 1'b0);
    end
    if (hreadyout === 1'b1) rd_ph = hsel && htrans[1] && !hwrite;
  end
  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    tally_and_finish();
  end
  // ----------
  // scenarios
  // ----------
  initial begin
    logic [15:0] v;
    void'($urandom(32'h08B4));
    v = 16'($urandom);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (al[i]) rd(al[i], 8'h00);
    // capture mode wraps from all ones and raises the flag
    wr(`CRBT_OFF_CNT_LO, 8'hFF);
    wr(`CRBT_OFF_CNT_HI, 8'hFF);
    wr(`CRBT_OFF_CTRL, 8'h01);
    wr(`CRBT_OFF_CTRL, 8'h05);
    repeat (30) @(posedge hclk);
    rd(`CRBT_OFF_CTRL, 8'h85);
    check("irq", timer_irq, 1'b1);
    wr(`CRBT_OFF_CTRL, 8'h00);
    rd(`CRBT_OFF_CNT_HI, 8'h00);
    // reload mode takes the capture value on overflow
    wr(`CRBT_OFF_CAP_LO, 8'h34);
    wr(`CRBT_OFF_CAP_HI, 8'h12);
    wr(`CRBT_OFF_CNT_LO, 8'hFF);
    wr(`CRBT_OFF_CNT_HI, 8'hFF);
    wr(`CRBT_OFF_CTRL, 8'h04);
    repeat (30) @(posedge hclk);
    rd(`CRBT_OFF_CTRL, 8'h84);
    rd(`CRBT_OFF_CNT_HI, 8'h12);
    // trigger captures a random count; counter mode with a quiet
    // count pin keeps the count still while the timer runs
    wr(`CRBT_OFF_CTRL, 8'h0B);
    wr(`CRBT_OFF_CNT_LO, v[7:0]);
    wr(`CRBT_OFF_CNT_HI, v[15:8]);
    wr(`CRBT_OFF_CTRL, 8'h0F);
    pulse(1'b1);
    rd(`CRBT_OFF_CAP_LO, v[7:0]);
    rd(`CRBT_OFF_CAP_HI, v[15:8]);
    rd(`CRBT_OFF_CTRL, 8'h4F);
    // trigger reloads in reload mode, again with a still count
    wr(`CRBT_OFF_CTRL, 8'h0A);
    wr(`CRBT_OFF_CNT_LO, 8'h00);
    wr(`CRBT_OFF_CNT_HI, 8'h00);
    wr(`CRBT_OFF_CTRL, 8'h0E);
    pulse(1'b1);
    rd(`CRBT_OFF_CNT_LO, v[7:0]);
    rd(`CRBT_OFF_CNT_HI, v[15:8]);
    rd(`CRBT_OFF_CTRL, 8'h4E);
    // external enable clear: the pin is ignored
    wr(`CRBT_OFF_CTRL, 8'h01);
    pulse(1'b1);
    rd(`CRBT_OFF_CTRL, 8'h01);
    // baud selects with the run bit clear (mode off): flag only, no reload
    wr(`CRBT_OFF_CTRL, 8'h38);
    pulse(1'b1);
    rd(`CRBT_OFF_CTRL, 8'h78);
    rd(`CRBT_OFF_CNT_LO, v[7:0]);
    // counter mode counts five pin falls, none once stopped
    wr(`CRBT_OFF_CNT_LO, 8'h00);
    wr(`CRBT_OFF_CNT_HI, 8'h00);
    wr(`CRBT_OFF_CTRL, 8'h02);
    wr(`CRBT_OFF_CTRL, 8'h06);
    pulse(1'b0);
    rd(`CRBT_OFF_CNT_LO, 8'h05);
    wr(`CRBT_OFF_CTRL, 8'h02);
    pulse(1'b0);
    rd(`CRBT_OFF_CNT_LO, 8'h05);
    // software sets and clears the flag like hardware
    wr(`CRBT_OFF_CTRL, 8'h80);
    @(negedge hclk);
    check("irq", timer_irq, 1'b1);
    wr(`CRBT_OFF_CTRL, 8'h00);
    @(negedge hclk);
    check("irq", timer_irq, 1'b0);
    // baud at state-time rate: one bit tick each way in 800 clocks
    wr(`CRBT_OFF_CAP_LO, 8'hF0);
    wr(`CRBT_OFF_CAP_HI, 8'hFF);
    wr(`CRBT_OFF_CNT_LO, 8'hF0);
    wr(`CRBT_OFF_CNT_HI, 8'hFF);
    serial_mode <= 2'b01;
    ticks = 0;
    wr(`CRBT_OFF_CTRL, 8'h34);
    repeat (800) @(posedge hclk);
    wr(`CRBT_OFF_CTRL, 8'h30);
    check("ticks", ticks, 2);
    rd(`CRBT_OFF_CTRL, 8'h30);
    repeat (5) @(posedge hclk);
    tally_and_finish();
  end
endmodule
